// *** esc_pkg.sv ***
// package for the extended store coupler: widths, parity helpers, states
// assumes both coupler ends and the storage controller end share one clock
package esc_pkg;
    localparam int ESC_DATA_W = 60;
    localparam int ESC_ADDR_W = 24;
    localparam int ESC_CNT_W = 18;
    localparam int ESC_FLAG_W = 6;
    localparam int ESC_REC_WORDS = 8;
    localparam int ESC_WIDX_W = 3;
    localparam logic [ESC_CNT_W-1:0] ESC_CNT_ONE = 18'h00001;
    localparam logic [ESC_ADDR_W-1:0] ESC_ADDR_ONE = 24'h000001;
    localparam logic ESC_PAR_REGEN = 1'b0;

    typedef enum logic [2:0] {
        ESC_IDLE = 3'b000,
        ESC_REQ = 3'b001,
        ESC_MOVE = 3'b010,
        ESC_DONE = 3'b011,
        ESC_ERR = 3'b100,
        ESC_FLAG = 3'b101
    } esc_state_t;

    // odd parity throughout the coupler
    function automatic logic esc_par_addr(input logic [ESC_ADDR_W-1:0] v);
        esc_par_addr = ~(^v);
    endfunction : esc_par_addr

    function automatic logic esc_par_cnt(input logic [ESC_CNT_W-1:0] v);
        esc_par_cnt = ~(^v);
    endfunction : esc_par_cnt

    function automatic logic esc_par_data(input logic [ESC_DATA_W-1:0] v);
        esc_par_data = ~(^v);
    endfunction : esc_par_data
endpackage : esc_pkg

// *** esc_link_if.sv ***
// interface between coupler and storage controller end
// assumes a single shared clock; no tristate on this link
`timescale 1ns/1ns
interface esc_link_if;
    import esc_pkg::*;
    logic req;
    logic wr;
    logic flag;
    logic [ESC_FLAG_W-1:0] flag_fn;
    logic [ESC_ADDR_W-1:0] addr;
    logic addr_par;
    logic [ESC_DATA_W-1:0] wdata;
    logic wpar;
    logic wvalid;
    logic [ESC_DATA_W-1:0] rdata;
    logic rpar;
    logic rvalid;
    logic accept;
    logic err;

    modport coupler (
        output req, wr, flag, flag_fn, addr, addr_par, wdata, wpar, wvalid,
        input rdata, rpar, rvalid, accept, err
    );
    modport store (
        input req, wr, flag, flag_fn, addr, addr_par, wdata, wpar, wvalid,
        output rdata, rpar, rvalid, accept, err
    );
endinterface : esc_link_if

// *** esc_word_ctr.sv ***
// word and address advance unit used by the coupler
// assumes clear and step never both asserted by caller with intent to keep
`timescale 1ns/1ns
module esc_word_ctr
    import esc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic step,
    input wire logic [ESC_ADDR_W-1:0] addr_in,
    input wire logic [ESC_CNT_W-1:0] cnt_in,
    output logic [ESC_ADDR_W-1:0] addr,
    output logic [ESC_CNT_W-1:0] moved,
    output logic at_count
);
    typedef struct packed {
        logic [ESC_ADDR_W-1:0] addr;
        logic [ESC_CNT_W-1:0] moved;
        logic [ESC_CNT_W-1:0] want;
    } esc_ctr_t;

    esc_ctr_t st_r;
    esc_ctr_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.addr = addr_in;
            st_nxt.moved = '0;
            st_nxt.want = cnt_in;
        end else if (step) begin
            st_nxt.addr = st_r.addr + ESC_ADDR_ONE;
            st_nxt.moved = st_r.moved + ESC_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign addr = st_r.addr;
    assign moved = st_r.moved;
    assign at_count = (st_r.moved == st_r.want);
endmodule : esc_word_ctr

// *** esc_coupler.sv ***
// coupler end: processor command, memory controller word port, storage link
// assumes memory controller answers each bank initiate with a strobe later
`timescale 1ns/1ns
module esc_coupler
    import esc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cp_start,
    input wire logic cp_wr,
    input wire logic cp_flag,
    input wire logic [ESC_FLAG_W-1:0] cp_flag_fn,
    input wire logic [ESC_ADDR_W-1:0] cp_addr,
    input wire logic cp_addr_par,
    input wire logic [ESC_CNT_W-1:0] cp_cnt,
    input wire logic cp_cnt_par,
    input wire logic [ESC_DATA_W-1:0] mmc_wdata,
    input wire logic mmc_wpar,
    input wire logic mmc_wvalid,
    input wire logic mmc_rtaken,
    output logic busy,
    output logic end_xfer,
    output logic err_xfer,
    output logic cont_req,
    output logic bank_init,
    output logic [ESC_DATA_W-1:0] mmc_rdata,
    output logic mmc_rpar,
    output logic mmc_rvalid,
    esc_link_if.coupler lnk
);
    typedef struct packed {
        esc_state_t state;
        logic wr;
        logic req;
        logic flag;
        logic [ESC_FLAG_W-1:0] flag_fn;
        logic [ESC_ADDR_W-1:0] addr;
        logic addr_par;
        logic [ESC_DATA_W-1:0] wdata;
        logic wpar;
        logic wvalid;
        logic [ESC_DATA_W-1:0] rdata;
        logic rpar;
        logic rvalid;
        logic cont;
        logic binit;
        logic wait_w;
        logic done;
        logic err;
        logic busy;
    } esc_cpl_t;

    esc_cpl_t st_r;
    esc_cpl_t st_nxt;
    logic ld;
    logic stp;
    logic [ESC_ADDR_W-1:0] cur_addr;
    logic at_cnt;
    logic par_bad;
    logic addr_bad;
    logic cnt_bad;

    ////////////////////////////////////////////////////////////////////////
    assign addr_bad = (esc_par_addr(cp_addr) != cp_addr_par);
    assign cnt_bad = (esc_par_cnt(cp_cnt) != cp_cnt_par);
    assign par_bad = addr_bad | cnt_bad;

    // moved count unused here; the compare lives in the counter
    esc_word_ctr esc_word_ctr_inst (
        .clk(clk),
        .arst_n(arst_n),
        .load(ld),
        .step(stp),
        .addr_in(cp_addr),
        .cnt_in(cp_cnt),
        .addr(cur_addr),
        .moved(),
        .at_count(at_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        ld = 1'b0;
        stp = 1'b0;
        st_nxt.binit = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.wvalid = 1'b0;
        if (mmc_rtaken) begin
            st_nxt.rvalid = 1'b0;
        end
        case (st_r.state)
            ESC_IDLE: begin
                // only idle takes a start; a start while busy is dropped
                st_nxt.req = 1'b0;
                st_nxt.cont = 1'b0;
                st_nxt.flag = 1'b0;
                if (cp_start && par_bad) begin
                    st_nxt.err = 1'b1;
                end else if (cp_start && cp_flag) begin
                    st_nxt.flag = 1'b1;
                    st_nxt.flag_fn = cp_flag_fn;
                    st_nxt.state = ESC_FLAG;
                end else if (cp_start) begin
                    ld = 1'b1;
                    st_nxt.wr = cp_wr;
                    st_nxt.state = ESC_REQ;
                end
            end
            ESC_FLAG: begin
                if (lnk.err) begin
                    st_nxt.err = 1'b1;
                    st_nxt.state = ESC_IDLE;
                end else if (lnk.accept) begin
                    st_nxt.flag = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.state = ESC_IDLE;
                end
            end
            ESC_REQ: begin
                st_nxt.addr = cur_addr;
                st_nxt.addr_par = esc_par_addr(cur_addr);
                if (at_cnt) begin
                    // count reached: no more bank initiates
                    st_nxt.req = 1'b0;
                    st_nxt.cont = 1'b0;
                    st_nxt.state = ESC_DONE;
                end else begin
                    st_nxt.req = 1'b1;
                    st_nxt.cont = 1'b1;
                    st_nxt.binit = 1'b1;
                    st_nxt.wait_w = 1'b1;
                    st_nxt.state = ESC_MOVE;
                end
            end
            ESC_MOVE: begin
                // drop the request at once; no word counts after an error
                if (lnk.err) begin
                    st_nxt.req = 1'b0;
                    st_nxt.cont = 1'b0;
                    st_nxt.state = ESC_ERR;
                end else if (st_r.wr && st_r.wait_w && mmc_wvalid) begin
                    st_nxt.wdata = mmc_wdata;
                    st_nxt.wpar = mmc_wpar;
                    st_nxt.wvalid = 1'b1;
                    st_nxt.wait_w = 1'b0;
                end else if (!st_r.wr && lnk.rvalid && !st_r.rvalid) begin
                    // a read word waits while memory still holds the last one
                    st_nxt.rdata = lnk.rdata;
                    st_nxt.rpar = lnk.rpar;
                    st_nxt.rvalid = 1'b1;
                    stp = 1'b1;
                    st_nxt.req = 1'b0;
                    st_nxt.state = ESC_REQ;
                end else if (st_r.wr && !st_r.wait_w && lnk.accept) begin
                    stp = 1'b1;
                    st_nxt.req = 1'b0;
                    st_nxt.state = ESC_REQ;
                end
            end
            ESC_DONE: begin
                // end pulse only on the clean path
                st_nxt.done = 1'b1;
                st_nxt.state = ESC_IDLE;
            end
            ESC_ERR: begin
                // error path raises no end pulse
                st_nxt.err = 1'b1;
                st_nxt.state = ESC_IDLE;
            end
            default: begin
                st_nxt.state = ESC_IDLE;
            end
        endcase
        // busy from a flop so the processor never sees a decode glitch
        st_nxt.busy = (st_nxt.state != ESC_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // all outputs straight from the state flops
    assign busy = st_r.busy;
    assign end_xfer = st_r.done;
    assign err_xfer = st_r.err;
    assign cont_req = st_r.cont;
    assign bank_init = st_r.binit;
    assign mmc_rdata = st_r.rdata;
    assign mmc_rpar = st_r.rpar;
    assign mmc_rvalid = st_r.rvalid;
    assign lnk.req = st_r.req;
    assign lnk.wr = st_r.wr;
    assign lnk.flag = st_r.flag;
    assign lnk.flag_fn = st_r.flag_fn;
    assign lnk.addr = st_r.addr;
    assign lnk.addr_par = st_r.addr_par;
    assign lnk.wdata = st_r.wdata;
    assign lnk.wpar = st_r.wpar;
    assign lnk.wvalid = st_r.wvalid;
endmodule : esc_coupler

// *** esc_store_end.sv ***
// storage controller end: one record of eight words, word references
// assumes one request outstanding at a time from the coupler
`timescale 1ns/1ns
module esc_store_end
    import esc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic regen_par,
    input wire logic fault,
    output logic [ESC_FLAG_W-1:0] last_flag,
    output logic flag_seen,
    esc_link_if.store lnk
);
    typedef struct packed {
        logic [ESC_DATA_W-1:0] rdata;
        logic rpar;
        logic rvalid;
        logic accept;
        logic err;
        logic [ESC_FLAG_W-1:0] lflag;
        logic fseen;
    } esc_st_t;

    // one record; bank address selects nothing beyond it in this model
    logic [ESC_DATA_W:0] rec_r [ESC_REC_WORDS];
    esc_st_t st_r;
    esc_st_t st_nxt;
    logic [ESC_WIDX_W-1:0] widx;
    logic apar_bad;
    logic wr_now;
    logic wpar_store;

    assign widx = lnk.addr[ESC_WIDX_W-1:0];
    assign apar_bad = (esc_par_addr(lnk.addr) != lnk.addr_par);
    assign wr_now = lnk.req && lnk.wr && lnk.wvalid && !apar_bad && !fault;
    assign wpar_store = regen_par ? esc_par_data(lnk.wdata) : lnk.wpar;

    always_comb begin
        st_nxt = st_r;
        st_nxt.accept = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.rvalid = 1'b0;
        if (lnk.flag && !st_r.accept) begin
            st_nxt.lflag = lnk.flag_fn;
            st_nxt.fseen = 1'b1;
            st_nxt.accept = 1'b1;
        end else if (lnk.req && (apar_bad || fault)) begin
            st_nxt.err = 1'b1;
        end else if (wr_now) begin
            st_nxt.accept = 1'b1;
        end else if (lnk.req && !lnk.wr && !st_r.rvalid) begin
            st_nxt.rdata = rec_r[widx][ESC_DATA_W-1:0];
            st_nxt.rpar = rec_r[widx][ESC_DATA_W];
            st_nxt.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage array has no reset, like the core it stands for
    always_ff @(posedge clk) begin
        if (wr_now) begin
            rec_r[widx] <= {wpar_store, lnk.wdata};
        end
    end

    assign lnk.rdata = st_r.rdata;
    assign lnk.rpar = st_r.rpar;
    assign lnk.rvalid = st_r.rvalid;
    assign lnk.accept = st_r.accept;
    assign lnk.err = st_r.err;
    assign last_flag = st_r.lflag;
    assign flag_seen = st_r.fseen;
endmodule : esc_store_end

// *** esc_link_checker.sv ***
// checker for the link between the coupler and the storage end
// assumes one clock; takes the signals of esc_link_if as plain inputs
`timescale 1ns/1ns
module esc_link_checker
    import esc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic flag,
    input wire logic [ESC_ADDR_W-1:0] addr,
    input wire logic addr_par,
    input wire logic wvalid,
    input wire logic rvalid,
    input wire logic accept,
    input wire logic err
);
    ////////////////////////////////////////////////////////////////////////
    // address of the last completed word and cycles since; saturates so
    // a new transfer long after the last word is not compared
    logic [ESC_ADDR_W-1:0] last_r;
    logic [3:0] gap_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_r <= '0;
            gap_r <= 4'hF;
        end else if (req && (rvalid || accept) && !flag) begin
            last_r <= addr;
            gap_r <= 4'h0;
        end else if (gap_r != 4'hF) begin
            gap_r <= gap_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence word_done;
        req && (rvalid || accept);
    endsequence
    sequence read_start;
        $rose(req) && !wr && !flag;
    endsequence
    a_addr_par_ok: assert property (req |-> addr_par == ~(^addr))
        else $error("link address parity wrong");
    a_req_hold: assert property (req && !rvalid && !accept && !err |=>
        req && $stable(addr) && $stable(wr)) else $error("request dropped early");
    a_read_answer: assert property (read_start |=> rvalid || err)
        else $error("read word not answered");
    a_flag_answer: assert property ($rose(flag) |=> accept || err)
        else $error("flag not accepted");
    a_write_accept: assert property (wvalid |=> accept || err)
        else $error("write word not accepted");
    a_answer_in_req: assert property ((rvalid || accept) |-> req || flag)
        else $error("answer without request");
    a_word_once: assert property (word_done |=> !rvalid && !accept)
        else $error("word answered twice");
    a_addr_step: assert property ($rose(req) && gap_r < 4'h8 |->
        addr == last_r + ESC_ADDR_ONE) else $error("address did not advance");
endmodule : esc_link_checker

// *** extended_store_coupler_bench.sv ***
// bench: coupler and storage end joined by esc_link_if
// assumes the memory controller side is played here and answers at once
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module extended_store_coupler_bench
    import esc_pkg::*;
;
    logic clk, arst_n, cp_start, cp_wr, cp_flag, cp_addr_par, cp_cnt_par;
    logic mmc_wpar, mmc_wvalid, mmc_rtaken, regen_par, fault, spoil_wpar;
    logic busy, end_xfer, err_xfer, cont_req, bank_init, mmc_rpar, mmc_rvalid, flag_seen;
    logic [ESC_FLAG_W-1:0] cp_flag_fn, last_flag;
    logic [ESC_ADDR_W-1:0] cp_addr, first_a, last_a;
    logic [ESC_CNT_W-1:0] cp_cnt;
    logic [ESC_DATA_W-1:0] mmc_wdata, mmc_rdata;
    logic [ESC_DATA_W-1:0] rd_q[$];
    logic rp_q[$];
    int n_errors, check_count, n_init, n_end, n_err, n_cont, k;
    ////////////////////////////////////////////////////////////////////////
    esc_link_if lnk_if();
    esc_coupler esc_coupler_inst (.clk(clk), .arst_n(arst_n), .cp_start(cp_start),
        .cp_wr(cp_wr), .cp_flag(cp_flag), .cp_flag_fn(cp_flag_fn), .cp_addr(cp_addr),
        .cp_addr_par(cp_addr_par), .cp_cnt(cp_cnt), .cp_cnt_par(cp_cnt_par),
        .mmc_wdata(mmc_wdata), .mmc_wpar(mmc_wpar), .mmc_wvalid(mmc_wvalid),
        .mmc_rtaken(mmc_rtaken), .busy(busy), .end_xfer(end_xfer), .err_xfer(err_xfer),
        .cont_req(cont_req), .bank_init(bank_init), .mmc_rdata(mmc_rdata),
        .mmc_rpar(mmc_rpar), .mmc_rvalid(mmc_rvalid), .lnk(lnk_if.coupler));
    esc_store_end esc_store_end_inst (.clk(clk), .arst_n(arst_n), .regen_par(regen_par),
        .fault(fault), .last_flag(last_flag), .flag_seen(flag_seen), .lnk(lnk_if.store));
    esc_link_checker esc_link_checker_inst (.clk(clk), .arst_n(arst_n), .req(lnk_if.req),
        .wr(lnk_if.wr), .flag(lnk_if.flag), .addr(lnk_if.addr), .addr_par(lnk_if.addr_par),
        .wvalid(lnk_if.wvalid), .rvalid(lnk_if.rvalid), .accept(lnk_if.accept),
        .err(lnk_if.err));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [ESC_DATA_W-1:0] word_of(input int i);
        word_of = {15{4'(i + 5)}};
    endfunction : word_of
    // memory controller side; counters restart with each start pulse
    always @(negedge clk) begin
        mmc_rtaken <= mmc_rvalid && !mmc_rtaken;
        mmc_wvalid <= bank_init && cp_wr;
        if (cp_start) begin
            // a parity refusal answers while start is still seen: keep it
            n_init <= 0;
            n_cont <= 0;
            n_end <= int'(end_xfer);
            n_err <= int'(err_xfer);
            rd_q.delete();
            rp_q.delete();
        end else begin
            if (mmc_rvalid && !mmc_rtaken) begin
                rd_q.push_back(mmc_rdata);
                rp_q.push_back(mmc_rpar);
            end
            if (bank_init) begin
                if (n_init == 0) first_a <= lnk_if.addr;
                last_a <= lnk_if.addr;
                n_init <= n_init + 1;
                n_cont <= n_cont + int'(cont_req);
                mmc_wdata <= word_of(n_init);
                mmc_wpar <= ~(^word_of(n_init)) ^ spoil_wpar;
            end
            n_end <= n_end + int'(end_xfer);
            n_err <= n_err + int'(err_xfer);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // bad[0] spoils address parity, bad[1] count parity
    task automatic start(input logic w, input logic f, input logic [ESC_ADDR_W-1:0] a,
        input logic [ESC_CNT_W-1:0] c, input logic [1:0] bad);
        int i;
        @(negedge clk);
        cp_wr <= w;
        cp_flag <= f;
        cp_addr <= a;
        cp_cnt <= c;
        cp_addr_par <= ~(^a) ^ bad[0];
        cp_cnt_par <= ~(^c) ^ bad[1];
        cp_start <= 1'b1;
        @(negedge clk);
        cp_start <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (n_end + n_err > 0) break;
        end
        if (i == 300) begin
            n_errors++;
            summarize();
        end
        // idle gap also lets late pulses show up in the counters
        repeat (12) @(negedge clk);
    endtask : start
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {cp_start, cp_wr, cp_flag, cp_addr_par, cp_cnt_par, mmc_wpar} = '0;
        {mmc_wvalid, mmc_rtaken, regen_par, fault, spoil_wpar} = '0;
        {cp_flag_fn, cp_addr, cp_cnt, mmc_wdata} = '0;
        {n_errors, check_count, n_init, n_end, n_err, n_cont} = '0;
        arst_n = 1'b0;
        repeat (10) @(negedge clk);
        arst_n <= 1'b1;
        // write three words across a record boundary, then read them back
        start(1'b1, 1'b0, 24'h000006, 18'h00003, 2'b00);
        `CHK(n_end, 1)
        `CHK(n_init, 3)
        `CHK(first_a, 24'h000006)
        `CHK(last_a, 24'h000008)
        `CHK(n_cont, 3)
        `CHK(busy, 1'b0)
        start(1'b0, 1'b0, 24'h000006, 18'h00003, 2'b00);
        `CHK(n_init, 3)
        for (k = 0; k < 3; k++) begin
            `CHK(rd_q[k], word_of(k))
            `CHK(rp_q[k], ~(^word_of(k)))
        end
        start(1'b1, 1'b0, 24'h000010, 18'h00000, 2'b00);
        `CHK(n_end, 1)
        `CHK(n_init, 0)
        for (k = 1; k < 4; k++) begin
            start(1'b0, 1'b0, 24'h000020, 18'h00002, 2'(k));
            `CHK(n_err, 1)
            `CHK(n_end, 0)
            `CHK(n_init, 0)
        end
        fault <= 1'b1;
        start(1'b1, 1'b0, 24'h000030, 18'h00004, 2'b00);
        `CHK(n_err, 1)
        `CHK(n_end, 0)
        `CHK(n_init, 1)
        `CHK(cont_req, 1'b0)
        fault <= 1'b0;
        cp_flag_fn <= 6'h2A;
        start(1'b0, 1'b1, 24'h000000, 18'h00000, 2'b00);
        `CHK(n_end, 1)
        `CHK(last_flag, 6'h2A)
        `CHK(flag_seen, 1'b1)
        // single word references: store regenerates, then passes, a spoiled parity
        regen_par <= 1'b1;
        spoil_wpar <= 1'b1;
        start(1'b1, 1'b0, 24'h000007, 18'h00001, 2'b00);
        start(1'b0, 1'b0, 24'h000007, 18'h00001, 2'b00);
        `CHK(rd_q[0], word_of(0))
        `CHK(rp_q[0], ~(^word_of(0)))
        regen_par <= 1'b0;
        start(1'b1, 1'b0, 24'h000005, 18'h00001, 2'b00);
        start(1'b0, 1'b0, 24'h000005, 18'h00001, 2'b00);
        `CHK(rd_q[0], word_of(0))
        `CHK(rp_q[0], ^word_of(0))
        spoil_wpar <= 1'b0;
        summarize();
    end
endmodule : extended_store_coupler_bench
